// *** verilog/bit_port_unit.sv ***
// bit port unit: eight two-way pins, pattern test flags, flag save register
// assumes the core moves words over the internal data bus with one-cycle strobes
`timescale 1ns/100ps
`include "bit_port_params.svh"
module bit_port_unit (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_b,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  input  wire bit_port_pkg::reg_sel_t i_sel,
  input  wire bit_port_pkg::word_t    i_wdata,
  output      bit_port_pkg::word_t    o_rdata,
  output      bit_port_pkg::flags_t   o_flags,
  input  wire bit_port_pkg::byte_t    i_port_pin,
  output      bit_port_pkg::byte_t    o_port_pin,
  output      bit_port_pkg::byte_t    o_port_pin_oe
);
  import bit_port_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  byte_t  dir;
  byte_t  out_latch;
  byte_t  pin_level;
  flags_t flags;
  word_t  rdata;

  // a pin move reaches the test three to four cycles later; software must wait
  pin_sync u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_pins  (i_port_pin),
    .o_level (pin_level)
  );

  // ----------------------------------------
  // select decode
  // ----------------------------------------
  function automatic logic sel_is(input reg_sel_t sel, input reg_sel_t code);
    return sel == code;
  endfunction : sel_is

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic   pick_state = sel_is(i_sel, `BP_SEL_STATE);
  wire logic   pick_ctrl  = sel_is(i_sel, `BP_SEL_CTRL);
  wire logic   pick_flags = sel_is(i_sel, `BP_SEL_FLAGS);
  wire logic   wr_state   = i_wr && pick_state;
  wire logic   wr_ctrl    = i_wr && pick_ctrl;
  wire logic   wr_flags   = i_wr && pick_flags;
  wire byte_t  mode     = i_wdata[`BP_DIR_HI:`BP_DIR_LO];
  wire byte_t  data     = i_wdata[`BP_VAL_HI:`BP_VAL_LO];
  wire byte_t  tested   = ~dir & mode;
  wire byte_t  match    = tested & ~(pin_level ^ data);
  wire byte_t  miss     = tested & (pin_level ^ data);
  wire logic   any_test = |tested;
  // mode 1 toggles on data one, mode 0 loads data
  wire byte_t  next_out_latch = (mode & (out_latch ^ data)) | (~mode & data);
  wire flags_t next_flags;

  assign next_flags[`BP_FLAG_ALL_HIT]  = any_test && (miss == 8'h00);
  assign next_flags[`BP_FLAG_NO_HIT]   = any_test && (match == 8'h00);
  assign next_flags[`BP_FLAG_ANY_HIT]  = |match;
  assign next_flags[`BP_FLAG_ANY_MISS] = |miss;

  wire word_t next_rdata = pick_state ? {dir, pin_level} :
                           pick_flags ? {12'h000, flags} :
                           pick_ctrl  ? {8'h00, out_latch} : 16'h0000;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dir <= `BP_DIR_RESET;
    end else if (wr_state) begin
      dir <= mode;
    end
  end

  // only output bits of the latch change; input bits keep their old value
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_latch <= `BP_LATCH_RESET;
    end else if (wr_ctrl) begin
      out_latch <= (dir & next_out_latch) | (~dir & out_latch);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags <= `BP_FLAGS_RESET;
    end else if (wr_ctrl) begin
      flags <= next_flags;
    end else if (wr_flags) begin
      flags <= i_wdata[3:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata <= 16'h0000;
    end else if (i_rd) begin
      rdata <= next_rdata;
    end
  end

  // one extra flop keeps the pins off decode glitches, at a cycle of latency
  byte_t pin_q;
  byte_t oe_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_q <= 8'h00;
      oe_q  <= 8'h00;
    end else begin
      pin_q <= out_latch;
      oe_q  <= dir;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_rdata       = rdata;
  assign o_flags       = flags;
  assign o_port_pin    = pin_q;
  assign o_port_pin_oe = oe_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // checks rebuild the test from raw bus fields rather than the decode wires
  wire byte_t  chk_tested = i_wdata[15:8] & ~dir;
  wire byte_t  chk_hit    = chk_tested & ~(i_wdata[7:0] ^ pin_level);
  wire byte_t  chk_miss   = chk_tested & (i_wdata[7:0] ^ pin_level);
  wire byte_t  chk_load   = dir & ~i_wdata[15:8];
  wire byte_t  chk_flip   = dir & i_wdata[15:8];

  sequence ctrl_write_s;
    wr_ctrl;
  endsequence
  sequence flag_write_s;
    wr_flags;
  endsequence
  sequence state_write_s;
    wr_state;
  endsequence
  sequence state_read_s;
    i_rd && pick_state;
  endsequence

  dir_reset_a: assert property (@(posedge i_clk) $rose(i_rst_b) |-> dir == 8'h00)
    else $error("direction not cleared by reset");
  latch_reset_a: assert property (@(posedge i_clk)
    $rose(i_rst_b) |-> out_latch == 8'h00)
    else $error("output latch not cleared by reset");
  flags_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_wr |=> $stable(flags)) else $error("flags changed without write");
  all_match_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ctrl_write_s |=> flags[0] == $past(chk_tested != 8'h00 && chk_hit == chk_tested))
    else $error("all-match flag wrong");
  none_match_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ctrl_write_s |=> flags[1] == $past(chk_tested != 8'h00 && chk_hit == 8'h00))
    else $error("none-match flag wrong");
  some_match_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ctrl_write_s |=> flags[2] == $past(chk_hit != 8'h00))
    else $error("any-match flag wrong");
  some_miss_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ctrl_write_s |=> flags[3] == $past(chk_miss != 8'h00))
    else $error("any-mismatch flag wrong");
  no_test_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_ctrl && chk_tested == 8'h00 |=> flags == 4'h0)
    else $error("untested write left flags");
  flags_restore_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    flag_write_s |=> flags == $past(i_wdata[3:0]))
    else $error("flag restore lost");
  dir_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    state_write_s |=> dir == $past(i_wdata[15:8]))
    else $error("direction write lost");
  latch_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ctrl_write_s |=> ((out_latch ^ $past(i_wdata[7:0])) & $past(chk_load)) == 8'h00)
    else $error("data mode bit not loaded");
  latch_toggle_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ctrl_write_s |=> ((out_latch ^ $past(out_latch ^ i_wdata[7:0])) & $past(chk_flip)) == 8'h00)
    else $error("toggle mode bit wrong");
  input_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ctrl_write_s |=> ((out_latch ^ $past(out_latch)) & $past(~dir)) == 8'h00)
    else $error("input pin latch changed");
  read_state_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    state_read_s |=> o_rdata == $past({dir, pin_level}))
    else $error("state read wrong");
  pin_drive_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ##1 o_port_pin == $past(out_latch))
    else $error("pin drive not following latch");
  input_latch_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_ctrl && dir == 8'h00 |=> $stable(out_latch)) else $error("input pins changed latch");
  drive_en_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ##1 o_port_pin_oe == $past(dir)) else $error("enable not following direction");
endmodule : bit_port_unit

// *** verilog/bit_port_params.svh ***
// constants for the bit port unit: register selects, field positions, reset values
// assumes inclusion by the unit and by the bench files
`ifndef BIT_PORT_PARAMS_SVH
`define BIT_PORT_PARAMS_SVH
`define BP_SEL_STATE     2'h0
`define BP_SEL_CTRL      2'h1
`define BP_SEL_FLAGS     2'h2
`define BP_DIR_HI        15
`define BP_DIR_LO        8
`define BP_VAL_HI        7
`define BP_VAL_LO        0
`define BP_FLAG_ALL_HIT  0
`define BP_FLAG_NO_HIT   1
`define BP_FLAG_ANY_HIT  2
`define BP_FLAG_ANY_MISS 3
`define BP_DIR_RESET     8'h00
`define BP_LATCH_RESET   8'h00
`define BP_FLAGS_RESET   4'h0
`endif

// *** verilog/bit_port_pkg.sv ***
// types shared by the bit port unit files
// assumes the params header sits beside it
package bit_port_pkg;
  typedef logic [1:0]  reg_sel_t;
  typedef logic [15:0] word_t;
  typedef logic [7:0]  byte_t;
  typedef logic [3:0]  flags_t;
endpackage : bit_port_pkg

// *** verilog/pin_sync.sv ***
// three-stage synchroniser for the eight port pins
// assumes pins are asynchronous to i_clk
`timescale 1ns/100ps
module pin_sync (
  input  wire logic                i_clk,
  input  wire logic                i_rst_b,
  input  wire bit_port_pkg::byte_t i_pins,
  output      bit_port_pkg::byte_t o_level
);
  import bit_port_pkg::*;
  byte_t s1;
  byte_t s2;
  byte_t s3;
  byte_t level;
  genvar g;
  // a bit changes only once stage two and three agree
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_bit
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          level[g] <= 1'b0;
        end else if (s2[g] == s3[g]) begin
          level[g] <= s3[g];
        end
      end
    end
  endgenerate
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1 <= 8'h00;
      s2 <= 8'h00;
      s3 <= 8'h00;
    end else begin
      s1 <= i_pins;
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign o_level = level;
endmodule : pin_sync

// *** tb/pin_partner.sv ***
// pin-side partner: outside sources on the eight port pins
// assumes the device drive and enable come straight from the unit
`timescale 1ns/100ps
module pin_partner (
  input  wire bit_port_pkg::byte_t i_drive,
  input  wire bit_port_pkg::byte_t i_drive_oe,
  input  wire bit_port_pkg::byte_t i_ext,
  output      bit_port_pkg::byte_t o_level
);
  import bit_port_pkg::*;
  // outside sources step back wherever the device drives
  assign o_level = (i_drive & i_drive_oe) | (i_ext & ~i_drive_oe);
endmodule : pin_partner

// *** tb/tb_bit_port_unit.sv ***
// bench for the bit port unit with an integer model of its registers
// assumes the pin partner and the design package are compiled first
`timescale 1ns/100ps
`include "bit_port_params.svh"
module tb_bit_port_unit;
  import bit_port_pkg::*;
  logic     i_clk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0;
  reg_sel_t i_sel = '0;
  word_t    i_wdata = '0, o_rdata;
  flags_t   o_flags;
  byte_t    ext = '0, pins, o_port_pin, o_port_pin_oe;
  int       fails = 0, tests_run = 0, dir = 0, lat = 0, exf = 0, seed;
  int       flag_q[$];
  always #5 i_clk = ~i_clk;
  bit_port_unit u_bit_port_unit (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_wr(i_wr), .i_rd(i_rd),
    .i_sel(i_sel), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_flags(o_flags),
    .i_port_pin(pins), .o_port_pin(o_port_pin), .o_port_pin_oe(o_port_pin_oe));
  pin_partner u_pin_partner (.i_drive(o_port_pin), .i_drive_oe(o_port_pin_oe),
    .i_ext(ext), .o_level(pins));
  // --------------------------------------------------
  // tasks
  // --------------------------------------------------
  task automatic chk(input word_t got, input word_t exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // generous settle covers pin follow-up and the synchroniser
  task automatic acc(input reg_sel_t s, input logic w, input word_t d);
    @(negedge i_clk);
    i_sel = s; i_wdata = d; i_wr = w; i_rd = ~w;
    @(negedge i_clk);
    i_wr = 0; i_rd = 0;
    repeat (5) @(negedge i_clk);
  endtask : acc
  task automatic ctrl(input word_t d);
    int lev, tst, m, nl;
    lev = ((lat & dir) | (ext & ~dir)) & 255;
    tst = d[15:8] & ~dir & 255;
    m = ~(lev ^ d[7:0]) & tst;
    nl = ((lat ^ d[7:0]) & d[15:8]) | (d[7:0] & ~d[15:8]);
    lat = ((lat & ~dir) | (nl & dir)) & 255;
    exf = (tst == 0) ? 0 : {m != tst, m != 0, m == 0, m == tst};
    flag_q.push_back(exf);
    acc(`BP_SEL_CTRL, 1, d);
    chk(word_t'(o_flags), word_t'(flag_q[$]));
    chk({o_port_pin_oe, o_port_pin & o_port_pin_oe},
        word_t'({dir[7:0], lat[7:0] & dir[7:0]}));
    // output pins now carry the new latch, so the read sees it there
    lev = ((lat & dir) | (ext & ~dir)) & 255;
    acc(`BP_SEL_STATE, 0, '0);
    chk(o_rdata, word_t'({dir[7:0], lev[7:0]}));
    acc(`BP_SEL_CTRL, 0, '0);
    chk(o_rdata, word_t'(lat));
  endtask : ctrl
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // --------------------------------------------------
  // sequence
  // --------------------------------------------------
  initial begin
    #200000;
    fails++;
    conclude;
  end
  initial begin
    seed = $urandom(32'ha640);
    repeat (6) @(negedge i_clk);
    i_rst_b = 1;
    for (int r = 0; r < 2; r++) begin
      ext = 8'h5a;
      // the synchroniser needs a few cycles before a read shows the pins
      repeat (5) @(negedge i_clk);
      acc(`BP_SEL_STATE, 0, '0);
      chk(o_rdata, 16'h005a);
      acc(`BP_SEL_CTRL, 0, '0);
      chk(o_rdata, 16'h0000);
      acc(`BP_SEL_FLAGS, 1, 16'hfffa);
      acc(`BP_SEL_FLAGS, 0, '0);
      chk(o_rdata, 16'h000a);
      chk(word_t'(o_flags), 16'h000a);
      ctrl(16'h00ab);
      ext = 8'hab;
      repeat (5) @(negedge i_clk);
      ctrl(16'hffab);
      for (int i = 0; i < 40; i++) begin
        if (i % 4 == 0) begin
          dir = $urandom & 255;
          acc(`BP_SEL_STATE, 1, word_t'({dir[7:0], 8'($urandom)}));
          chk(word_t'(o_flags), word_t'(flag_q[$]));
        end
        ext = 8'($urandom);
        repeat (5) @(negedge i_clk);
        ctrl(word_t'($urandom));
      end
      // mid-run reset must drop directions and latches again
      i_rst_b = 0;
      dir = 0; lat = 0; exf = 0;
      repeat (2) @(negedge i_clk);
      i_rst_b = 1;
    end
    acc(2'h3, 0, '0);
    chk(o_rdata, 16'h0000);
    conclude;
  end
endmodule : tb_bit_port_unit
